// ---- design/rtc_pkg.sv ----
package rtc_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] OFF_CFG   = 8'h00;  // Clock configuration and calibration
    localparam logic [7:0] OFF_PAD   = 8'h04;  // Pad output configuration
    localparam logic [7:0] OFF_ALCFG = 8'h08;  // Alarm configuration and repeat
    localparam logic [7:0] OFF_TWIN  = 8'h0c;  // Time value window
    localparam logic [7:0] OFF_AWIN  = 8'h10;  // Alarm value window
    localparam logic [7:0] OFF_KEY   = 8'h14;  // Unlock key, write only

    // Configuration register fields
    localparam int CFG_EN_BIT    = 15;
    localparam int CFG_WREN_BIT  = 13;
    localparam int CFG_SYNC_BIT  = 12;
    localparam int CFG_HALF_BIT  = 11;
    localparam int CFG_OE_BIT    = 10;
    localparam int PTR_LSB       = 8;
    localparam int PAD_SEL_BIT   = 1;
    localparam int PAD_TTL_BIT   = 0;
    localparam int AL_EN_BIT     = 15;
    localparam int AL_ALARM_ROLLOVER_A_BIT  = 14;
    localparam int AL_MASK_LSB   = 10;

    // Unlock key values
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // Pointer codes, reset value and repeat rollover value
    localparam logic [1:0]  PTR_MINUTES_SECONDS_REGISTER = 2'h0;
    localparam logic [1:0]  PTR_UNIMPL = 2'h3;
    localparam logic [15:0] VAL_RESET  = 16'h0000;
    localparam logic [7:0]  RPT_ROLL   = 8'hff;

    // Writable bits of each time pair (min/sec, wday/hr, mon/day, year)
    localparam logic [15:0] TIME_MASK [4] = '{16'h7f7f, 16'h073f, 16'h1f3f, 16'h00ff};

    // Time base: 32.768 kHz oscillator, half second of ticks
    localparam int          OSC_HZ     = 32768;
    localparam logic [13:0] HALF_LAST  = 14'(OSC_HZ / 2 - 1);
    localparam logic [13:0] SYNC_START = 14'(OSC_HZ / 2 - 32);

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Alarm interval codes
    localparam logic [3:0] AM_HALF  = 4'h0;
    localparam logic [3:0] AM_SEC   = 4'h1;
    localparam logic [3:0] AM_10SEC = 4'h2;
    localparam logic [3:0] AM_MIN   = 4'h3;
    localparam logic [3:0] AM_10MIN = 4'h4;
    localparam logic [3:0] AM_HOUR  = 4'h5;
    localparam logic [3:0] AM_DAY   = 4'h6;
    localparam logic [3:0] AM_WEEK  = 4'h7;
    localparam logic [3:0] AM_MONTH = 4'h8;
    localparam logic [3:0] AM_YEAR  = 4'h9;

    // Unlock sequence states
    typedef enum logic [1:0] {
        UL_IDLE  = 2'b00,
        UL_GOT55 = 2'b01,
        UL_OPEN  = 2'b10
    } unlock_t;
endpackage

// ---- design/ptr_if.sv ----
`timescale 1ns/1ps
interface ptr_if;
    logic       load;      // Software loads a new pointer
    logic [1:0] load_val;  // Value to load
    logic       rd;        // Window read, one cycle
    logic       wr_hi;     // Accepted upper-byte write, one cycle
    logic [1:0] ptr;       // Current pointer
    modport owner (input load, input load_val, input rd, input wr_hi, output ptr);
    modport user  (output load, output load_val, output rd, output wr_hi, input ptr);
endinterface

// ---- design/window_ptr.sv ----
`timescale 1ns/1ps
module window_ptr
    import rtc_pkg::*;
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic rst_n,
    // Pointer port
    ptr_if.owner      p
);
    logic [1:0] ptr_r;  // Pointer state

    // Load wins; otherwise step down and park at zero
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            ptr_r <= PTR_MINUTES_SECONDS_REGISTER;
        end else if (p.load) begin
            ptr_r <= p.load_val;
        end else if ((p.rd || p.wr_hi) && ptr_r != PTR_MINUTES_SECONDS_REGISTER) begin
            ptr_r <= ptr_r - 2'h1;
        end
    end

    assign p.ptr = ptr_r;

    a_ptr_step: assert property (@(posedge aclk) disable iff (!rst_n)
        (p.rd || p.wr_hi) && !p.load && ptr_r != 2'h0 |=> ptr_r == $past(ptr_r) - 2'h1)
        else $error("pointer did not step down");
    a_ptr_park: assert property (@(posedge aclk) disable iff (!rst_n)
        ptr_r == 2'h0 && !p.load |=> ptr_r == 2'h0)
        else $error("pointer left zero without a load");
endmodule

// ---- design/rtc_ctrl.sv ----
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Function
// - Alarm pointer picks alarm window pair
// - Alarm upper-byte write steps pointer down
// - Pointer at zero stays on min/sec
// - Any alarm window read steps pointer down
// - Any time window read steps pointer down
// - Time pointer picks time window pair
// - Time upper-byte write steps pointer down
// - Time writes ignored unless write enabled
// - Write enable set only after key pair
// - Module enable writable only while write enabled
// - Sync flag warns of rollover ripple
// - Low min/sec write clears half-second bit
// - Configuration register reset only at power-on
// - Select bit routes second clock or alarm
// - Pin driven only while output enabled
// - Alarm mask selects alarm interval
module rtc_ctrl
    import rtc_pkg::*;
(
    // Clock, power-on reset, other resets
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       sys_rst_n,
    // Oscillator pin
    input  wire logic       osc_in,
    // Write address channel
    input  wire logic [7:0] s_axi_awaddr,
    input  wire logic       s_axi_awvalid,
    output logic            s_axi_awready,
    // Write data channel
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // Write response channel
    output logic [1:0]      s_axi_bresp,
    output logic            s_axi_bvalid,
    input  wire logic       s_axi_bready,
    // Read address channel
    input  wire logic [7:0] s_axi_araddr,
    input  wire logic       s_axi_arvalid,
    output logic            s_axi_arready,
    // Read data channel
    output logic [31:0]     s_axi_rdata,
    output logic [1:0]      s_axi_rresp,
    output logic            s_axi_rvalid,
    input  wire logic       s_axi_rready,
    // Clock output pin
    output logic            clk_out,
    output logic            clk_out_en
);
    import rtc_pkg::*;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Bus write holding state
    logic        aw_held_r;     // Address taken
    logic [7:0]  awaddr_r;      // Held write address
    logic        w_held_r;      // Data taken
    logic [15:0] wdata_r;       // Held write data, low half only
    logic [1:0]  wstrb_r;       // Held lanes 1:0
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    // Configuration fields
    logic        module_en_r;   // Clock module enable
    logic        wren_r;        // Time write enable
    logic        oe_r;          // Clock output enable
    logic [7:0]  cal_r;         // Calibration byte, stored only
    logic        sel_r;         // Output source select
    logic        ttl_r;         // Unrelated pad bit, stored only
    logic        alarm_en_r;
    logic        alarm_rollover_a_r;       // Repeat counter may roll over
    logic [3:0]  alarm_interval_mask_r;       // Alarm interval
    logic [7:0]  alarm_repeat_count_r;        // Alarm repeat count
    unlock_t     ul_state;      // Key sequence tracker

    // Value stores
    logic [15:0] time_r  [4];   // Time pairs
    logic [15:0] alarm_r [3];   // Alarm pairs

    // Time base
    logic [2:0]  osc_sync_r;    // Three-stage pin synchroniser
    logic        osc_lvl_r;     // Accepted oscillator level
    logic [13:0] tick_cnt_r;    // Ticks in current half second
    logic        half_r;        // Half-second status
    logic        alarm_pulse_r; // Alarm pulse for the pin

    // Decoded strobes
    logic do_wr, do_rd, wr_cfg, wr_pad, wr_alcfg, wr_twin, wr_awin, wr_key;
    logic rd_twin, rd_awin, osc_rise, half_tick, sec_tick, alarm_evt, sync_flag;
    logic mapped_w, mapped_r, time_wr_ok, key_first, key_second;

    // Pointer carriers
    ptr_if tp ();
    ptr_if ap ();

    window_ptr u_time_ptr (
        .aclk  (aclk),
        .rst_n (aresetn),
        .p     (tp.owner)
    );
    window_ptr u_alarm_ptr (
        .aclk  (aclk),
        .rst_n (aresetn && sys_rst_n),
        .p     (ap.owner)
    );

    // Handshake outputs
    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready  = !w_held_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // Write fires once both halves are held and no answer is pending
    assign do_wr    = aw_held_r && w_held_r && !bvalid_r;
    assign do_rd    = s_axi_arvalid && !rvalid_r;
    assign wr_cfg   = do_wr && awaddr_r == OFF_CFG;
    assign wr_pad   = do_wr && awaddr_r == OFF_PAD;
    assign wr_alcfg = do_wr && awaddr_r == OFF_ALCFG;
    assign wr_twin  = do_wr && awaddr_r == OFF_TWIN;
    assign wr_awin  = do_wr && awaddr_r == OFF_AWIN;
    assign wr_key   = do_wr && awaddr_r == OFF_KEY;
    assign rd_twin  = do_rd && s_axi_araddr == OFF_TWIN;
    assign rd_awin  = do_rd && s_axi_araddr == OFF_AWIN;
    assign mapped_w = awaddr_r inside {OFF_CFG, OFF_PAD, OFF_ALCFG, OFF_TWIN, OFF_AWIN, OFF_KEY};
    assign mapped_r = s_axi_araddr inside {OFF_CFG, OFF_PAD, OFF_ALCFG, OFF_TWIN, OFF_AWIN};
    assign time_wr_ok = wr_twin && wren_r;
    assign key_first  = wr_key && wstrb_r[0] && wdata_r[7:0] == KEY_FIRST;
    assign key_second = wr_key && wstrb_r[0] && wdata_r[7:0] == KEY_SECOND;

    // Pointer requests
    assign tp.load     = wr_cfg && wstrb_r[1];
    assign tp.load_val = wdata_r[PTR_LSB +: 2];
    assign tp.rd       = rd_twin;
    assign tp.wr_hi    = time_wr_ok && wstrb_r[1];
    assign ap.load     = wr_alcfg && wstrb_r[1];
    assign ap.load_val = wdata_r[PTR_LSB +: 2];
    assign ap.rd       = rd_awin;
    assign ap.wr_hi    = wr_awin && wstrb_r[1];

    // Write address and data capture, answer after the write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= VAL_RESET;
            wstrb_r   <= 2'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held_r) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && !w_held_r) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata[15:0];
                wstrb_r  <= s_axi_wstrb[1:0];
            end
            if (do_wr) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= mapped_w ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read data is registered; the window pointer steps at the same edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end else if (do_rd) begin
            rvalid_r <= 1'b1;
            rresp_r  <= mapped_r ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                OFF_CFG:   rdata_r <= {16'h0000, module_en_r, 1'b0, wren_r, sync_flag,
                                       half_r, oe_r, tp.ptr, cal_r};
                OFF_PAD:   rdata_r <= {30'h0, sel_r, ttl_r};
                OFF_ALCFG: rdata_r <= {16'h0000, alarm_en_r, alarm_rollover_a_r, alarm_interval_mask_r, ap.ptr, alarm_repeat_count_r};
                OFF_TWIN:  rdata_r <= {16'h0000, time_r[tp.ptr]};
                OFF_AWIN:  rdata_r <= (ap.ptr == PTR_UNIMPL) ? 32'h0 :
                                      {16'h0000, alarm_r[ap.ptr]};
                default:   rdata_r <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Key pair opens a window of exactly the next bus write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ul_state <= UL_IDLE;
        end else if (do_wr) begin
            unique case (ul_state)
                UL_IDLE:  ul_state <= key_first ? UL_GOT55 : UL_IDLE;
                UL_GOT55: ul_state <= key_second ? UL_OPEN :
                                      (key_first ? UL_GOT55 : UL_IDLE);
                UL_OPEN:  ul_state <= key_first ? UL_GOT55 : UL_IDLE;
                default:  ul_state <= UL_IDLE;
            endcase
        end
    end

    // Configuration register: power-on reset only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            module_en_r <= 1'b0;
            wren_r      <= 1'b0;
            oe_r        <= 1'b0;
            cal_r       <= 8'h00;
        end else if (wr_cfg) begin
            if (wstrb_r[1]) begin
                // Clearing is always allowed, setting needs the open window
                if (!wdata_r[CFG_WREN_BIT]) begin
                    wren_r <= 1'b0;
                end else if (ul_state == UL_OPEN) begin
                    wren_r <= 1'b1;
                end
                if (wren_r) begin
                    module_en_r <= wdata_r[CFG_EN_BIT];
                end
                oe_r <= wdata_r[CFG_OE_BIT];
            end
            if (wstrb_r[0]) begin
                cal_r <= wdata_r[7:0];
            end
        end
    end

    // Pad configuration, cleared by any reset
    always_ff @(posedge aclk) begin
        if (!aresetn || !sys_rst_n) begin
            sel_r <= 1'b0;
            ttl_r <= 1'b0;
        end else if (wr_pad && wstrb_r[0]) begin
            sel_r <= wdata_r[PAD_SEL_BIT];
            ttl_r <= wdata_r[PAD_TTL_BIT];
        end
    end

    // Alarm configuration; hardware countdown yields to a software write
    always_ff @(posedge aclk) begin
        if (!aresetn || !sys_rst_n) begin
            alarm_en_r <= 1'b0;
            alarm_rollover_a_r    <= 1'b0;
            alarm_interval_mask_r    <= AM_HALF;
            alarm_repeat_count_r     <= 8'h00;
        end else if (wr_alcfg) begin
            if (wstrb_r[1]) begin
                alarm_en_r <= wdata_r[AL_EN_BIT];
                alarm_rollover_a_r    <= wdata_r[AL_ALARM_ROLLOVER_A_BIT];
                alarm_interval_mask_r    <= wdata_r[AL_MASK_LSB +: 4];
            end
            if (wstrb_r[0]) begin
                alarm_repeat_count_r <= wdata_r[7:0];
            end
        end else if (alarm_evt) begin
            if (alarm_repeat_count_r == 8'h00 && !alarm_rollover_a_r) begin
                alarm_en_r <= 1'b0;
            end else begin
                alarm_repeat_count_r <= (alarm_repeat_count_r == 8'h00) ? RPT_ROLL : alarm_repeat_count_r - 8'h01;
            end
        end
    end

    // Time values; per-byte writes masked to the implemented bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            time_r <= '{default: VAL_RESET};
        end else if (time_wr_ok) begin
            if (wstrb_r[1]) begin
                time_r[tp.ptr][15:8] <= wdata_r[15:8] & TIME_MASK[tp.ptr][15:8];
            end
            if (wstrb_r[0]) begin
                time_r[tp.ptr][7:0] <= wdata_r[7:0] & TIME_MASK[tp.ptr][7:0];
            end
        end
    end

    // Alarm values; the unimplemented pair takes no write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_r <= '{default: VAL_RESET};
        end else if (wr_awin && ap.ptr != PTR_UNIMPL) begin
            if (wstrb_r[1]) begin
                alarm_r[ap.ptr][15:8] <= wdata_r[15:8] & TIME_MASK[ap.ptr][15:8];
            end
            if (wstrb_r[0]) begin
                alarm_r[ap.ptr][7:0] <= wdata_r[7:0] & TIME_MASK[ap.ptr][7:0];
            end
        end
    end

    // Oscillator pin: a level is accepted once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_sync_r <= 3'h0;
            osc_lvl_r  <= 1'b0;
        end else begin
            osc_sync_r <= {osc_sync_r[1:0], osc_in};
            if (osc_sync_r[1] == osc_sync_r[2]) begin
                osc_lvl_r <= osc_sync_r[2];
            end
        end
    end

    assign osc_rise  = osc_sync_r[1] && osc_sync_r[2] && !osc_lvl_r;
    assign half_tick = module_en_r && osc_rise && tick_cnt_r == HALF_LAST;
    assign sec_tick  = half_tick && half_r;
    // Window near a rollover in which a read may see ripple
    assign sync_flag = module_en_r && tick_cnt_r >= SYNC_START;

    // Half-second phase; a pending toggle to one beats the software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_r <= 14'h0000;
            half_r     <= 1'b0;
        end else begin
            if (module_en_r && osc_rise) begin
                tick_cnt_r <= (tick_cnt_r == HALF_LAST) ? 14'h0000 : tick_cnt_r + 14'h0001;
            end
            if (half_tick) begin
                half_r <= !half_r;
            end else if (time_wr_ok && wstrb_r[0] && tp.ptr == PTR_MINUTES_SECONDS_REGISTER) begin
                half_r <= 1'b0;
            end
        end
    end

    // Field comparison against the stored alarm, coarser masks add fields except month, which checks day in place of weekday
    logic m_s1, m_s, m_m1, m_m, m_h, m_w, m_d, m_mo, fire;
    assign m_s1 = time_r[0][3:0]  == alarm_r[0][3:0];
    assign m_s  = time_r[0][6:0]  == alarm_r[0][6:0];
    assign m_m1 = time_r[0][11:8] == alarm_r[0][11:8];
    assign m_m  = time_r[0][14:8] == alarm_r[0][14:8];
    assign m_h  = time_r[1][5:0]  == alarm_r[1][5:0];
    assign m_w  = time_r[1][10:8] == alarm_r[1][10:8];
    assign m_d  = time_r[2][5:0]  == alarm_r[2][5:0];
    assign m_mo = time_r[2][12:8] == alarm_r[2][12:8];

    always_comb begin
        unique case (alarm_interval_mask_r)
            AM_HALF:  fire = half_tick;
            AM_SEC:   fire = sec_tick;
            AM_10SEC: fire = sec_tick && m_s1;
            AM_MIN:   fire = sec_tick && m_s;
            AM_10MIN: fire = sec_tick && m_s && m_m1;
            AM_HOUR:  fire = sec_tick && m_s && m_m;
            AM_DAY:   fire = sec_tick && m_s && m_m && m_h;
            AM_WEEK:  fire = sec_tick && m_s && m_m && m_h && m_w;
            AM_MONTH: fire = sec_tick && m_s && m_m && m_h && m_d;
            AM_YEAR:  fire = sec_tick && m_s && m_m && m_h && m_d && m_mo;
            default:  fire = 1'b0; // Reserved codes never fire
        endcase
    end

    assign alarm_evt = fire && alarm_en_r;

    // Alarm pulse lasts until the next half-second tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_pulse_r <= 1'b0;
        end else if (alarm_evt) begin
            alarm_pulse_r <= 1'b1;
        end else if (half_tick) begin
            alarm_pulse_r <= 1'b0;
        end
    end

    // Pin source and enable, registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_out    <= 1'b0;
            clk_out_en <= 1'b0;
        end else begin
            clk_out    <= oe_r && (sel_r ? half_r : alarm_pulse_r);
            clk_out_en <= oe_r;
        end
    end

    sequence s_last_alarm;
        alarm_evt && !wr_alcfg && alarm_repeat_count_r == 8'h00 && !alarm_rollover_a_r;
    endsequence

    a_time_lock: assert property (wr_twin && !wren_r |=> $stable(time_r[0]))
        else $error("time changed while locked");
    a_enable_guard: assert property (wr_cfg && !wren_r |=> $stable(module_en_r))
        else $error("module enable changed while locked");
    a_unlock_only: assert property ($rose(wren_r) |-> $past(ul_state) == UL_OPEN)
        else $error("write enable set without key pair");
    a_half_clear: assert property (
        time_wr_ok && wstrb_r[0] && tp.ptr == 2'h0 && !half_tick |=> !half_r)
        else $error("half-second bit not cleared");
    a_pin_gate: assert property (!oe_r ##1 1'b1 |-> !clk_out_en && !clk_out)
        else $error("pin driven while output disabled");
    a_pin_source: assert property (oe_r && sel_r |=> clk_out == $past(half_r))
        else $error("second clock not on pin");
    a_alarm_autoclear: assert property (s_last_alarm |=> !alarm_en_r)
        else $error("alarm stayed enabled at zero repeat");
    a_repeat_step: assert property (alarm_evt && !wr_alcfg && sys_rst_n
        && (alarm_repeat_count_r != 8'h00 || alarm_rollover_a_r) |=> alarm_repeat_count_r == $past(alarm_repeat_count_r) - 8'h01)
        else $error("repeat counter did not step");
    a_alarm_cause: assert property (alarm_evt |-> alarm_en_r && module_en_r)
        else $error("alarm without enable");
    a_reserved_mask: assert property (alarm_interval_mask_r[3] && alarm_interval_mask_r[2:1] != 2'h0 |-> !alarm_evt)
        else $error("reserved mask fired");
endmodule

// ---- test/test_rtc_ctrl.sv ----
`timescale 1ns/1ps
// Compare, count, report a mismatch at once
`define CK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module test_rtc_ctrl;
    import rtc_pkg::*;
    logic        aclk, aresetn, sys_rst_n, osc_in, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready, clk_out, clk_out_en;
    logic        ta, tw, hb;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    logic [15:0] rd;
    int          err_total, n_checks, n;
    // Alarm pairs by pointer; code 3 is unimplemented
    logic [15:0] al [4] = '{16'h1234, 16'h0512, 16'h1225, 16'h0000};

    rtc_ctrl rtc_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .sys_rst_n(sys_rst_n),
        .osc_in(osc_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .clk_out(clk_out), .clk_out_en(clk_out_en));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Every handshake wait is bounded
    task automatic hang();
        n++;
        if (n > 64) begin
            err_total++;
            $display("[FAIL] bus wait ran out");
            report_and_stop();
        end
    endtask

    // Ready is sampled mid-cycle, so the edge decision never races the slave
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s = 4'h3);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        hb = 1'b0;
        n = 0;
        while (!hb) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            hb = bvalid === 1'b1;
            rsp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            hang();
        end
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hb = 1'b0;
        n = 0;
        while (!hb) begin
            @(negedge aclk);
            ta = arvalid && arready;
            hb = rvalid === 1'b1;
            rd = rdata[15:0];
            rsp = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            hang();
        end
        rready <= 1'b0;
    endtask

    // Oscillator ticks, slow enough for the input synchroniser
    task automatic osc(input int k);
        repeat (k) begin
            @(posedge aclk) osc_in <= 1'b1;
            repeat (2) @(posedge aclk);
            osc_in <= 1'b0;
            @(posedge aclk);
        end
        repeat (8) @(negedge aclk);
    endtask

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    initial begin
        {aresetn, sys_rst_n, osc_in, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        err_total = 0;
        n_checks = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        sys_rst_n <= 1'b1;
        rdr(OFF_CFG);
        `CK("cfg reset", 16'h0000, rd)
        rdr(8'h40);
        `CK("unmapped", RESP_SLVERR, rsp)
        wr(8'h40, 16'h0000);
        `CK("unmapped write", RESP_SLVERR, rsp)
        wr(OFF_CFG, 16'h8000);
        `CK("write okay", RESP_OKAY, rsp)
        wr(OFF_TWIN, 16'h1234);
        rdr(OFF_CFG);
        `CK("enable locked", 16'h0000, rd)
        rdr(OFF_TWIN);
        `CK("time locked", 16'h0000, rd)
        // Key pair, then a pad write uses up the window before the enable write
        wr(OFF_KEY, KEY_FIRST);
        wr(OFF_KEY, KEY_SECOND);
        wr(OFF_PAD, 16'h0000);
        wr(OFF_CFG, 16'h2000);
        rdr(OFF_CFG);
        `CK("late unlock", 16'h0000, rd)
        wr(OFF_KEY, KEY_FIRST);
        wr(OFF_KEY, KEY_SECOND);
        wr(OFF_CFG, 16'h2300);
        wr(OFF_CFG, 16'ha700);
        rdr(OFF_CFG);
        `CK("unlocked", 16'ha700, rd)
        $display("lock test done");
        for (int i = 3; i >= 0; i--) wr(OFF_TWIN, 16'hffff);
        rdr(OFF_CFG);
        `CK("time ptr floor", 2'h0, rd[9:8])
        wr(OFF_CFG, 16'ha700);
        for (int i = 4; i >= 0; i--) begin
            rdr(OFF_TWIN);
            `CK("time pair", TIME_MASK[i > 0 ? i - 1 : 0], rd)
        end
        $display("time window test done");
        wr(OFF_ALCFG, 16'h0300);
        for (int i = 3; i >= 0; i--) wr(OFF_AWIN, al[i]);
        rdr(OFF_ALCFG);
        `CK("alarm ptr floor", 16'h0000, rd)
        wr(OFF_ALCFG, 16'h0300);
        for (int i = 4; i >= 0; i--) begin
            rdr(OFF_AWIN);
            `CK("alarm pair", al[i > 0 ? i - 1 : 0], rd)
        end
        wr(OFF_ALCFG, 16'h0200);
        wr(OFF_AWIN, 16'h0025, 4'h1);
        rdr(OFF_ALCFG);
        `CK("low write keeps ptr", 2'h2, rd[9:8])
        $display("alarm window test done");
        // Half-second alarm, one repeat, pin on alarm pulse
        wr(OFF_ALCFG, 16'h8001);
        osc(16360);
        rdr(OFF_CFG);
        `CK("sync", 2'b10, rd[12:11])
        `CK("pin idle", 2'b01, {clk_out, clk_out_en})
        osc(24);
        rdr(OFF_CFG);
        `CK("half", 2'b01, rd[12:11])
        `CK("alarm pin", 1'b1, clk_out)
        rdr(OFF_ALCFG);
        `CK("repeat", 16'h8000, rd)
        wr(OFF_PAD, 16'h0002);
        repeat (3) @(negedge aclk);
        `CK("second pin", 1'b1, clk_out)
        wr(OFF_CFG, 16'ha000);
        repeat (3) @(negedge aclk);
        `CK("pin off", 2'b00, {clk_out, clk_out_en})
        wr(OFF_TWIN, 16'h0000, 4'h1);
        rdr(OFF_CFG);
        `CK("half cleared", 1'b0, rd[11])
        $display("status and pin test done");
        sys_rst_n <= 1'b0;
        repeat (2) @(posedge aclk);
        sys_rst_n <= 1'b1;
        rdr(OFF_CFG);
        `CK("cfg kept", 3'b101, rd[15:13])
        wr(OFF_CFG, 16'h8000);
        rdr(OFF_CFG);
        `CK("relock", 3'b100, rd[15:13])
        rdr(OFF_ALCFG);
        `CK("alarm cfg reset", 16'h0000, rd)
        $display("reset test done");
        report_and_stop();
    end
endmodule
